// ---- mft_pkg.sv ----
// Package for the multi-function timer unit: offsets, fields, encodings
`default_nettype none
package mft_pkg;
    localparam logic [3:0] OFF_CTRL   = 4'h0;
    localparam logic [3:0] OFF_CLKSEL = 4'h1;
    localparam logic [3:0] OFF_PRSC   = 4'h2;
    localparam logic [3:0] OFF_CNT1   = 4'h3;
    localparam logic [3:0] OFF_CNT2   = 4'h4;
    localparam logic [3:0] OFF_CRA    = 4'h5;
    localparam logic [3:0] OFF_CRB    = 4'h6;
    localparam logic [3:0] OFF_IEN    = 4'h7;
    localparam logic [3:0] OFF_PND    = 4'h8;
    localparam logic [3:0] OFF_PCLR   = 4'h9;
    // Control field positions
    localparam int CTL_MODE_LSB  = 0;
    localparam int CTL_AEN       = 2;
    localparam int CTL_BEN       = 3;
    localparam int CTL_AOUT      = 4;
    localparam int CTL_AEDGE     = 5;
    localparam int CTL_BEDGE     = 6;
    localparam int CTL_PSAVE     = 7;
    localparam logic [7:0] CTRL_RST   = 8'h00;
    localparam logic [15:0] ALL_ONES  = 16'hffff;
    localparam logic [15:0] CNT_RST   = 16'h0000;
    localparam logic [4:0]  PRSC_RST  = 5'h00;
    localparam logic [15:0] RD_ZERO   = 16'h0000;

    typedef enum logic [1:0] {
        MFT_MODE_PWM  = 2'b00,
        MFT_MODE_CAP  = 2'b01,
        MFT_MODE_DUAL = 2'b10,
        MFT_MODE_RSVD = 2'b11
    } mft_mode_t;

    typedef enum logic [2:0] {
        MFT_CLK_NONE  = 3'b000,
        MFT_CLK_PRSC  = 3'b001,
        MFT_CLK_EVENT = 3'b010,
        MFT_CLK_PACC  = 3'b011,
        MFT_CLK_SLOW  = 3'b100
    } mft_clk_t;
endpackage
`default_nettype wire

// ---- mft_timer.sv ----
// Multi-function timer unit: two down-counters, reload/capture, pins A and B
`default_nettype none
// Behaviour
// - Pin B edge counts, selectable polarity
// - No event clock in capture mode
// - Pulse accumulate: prescaler tick while B active
// - No pulse accumulate in capture mode
// - Slow clock synchronised before use
// - Slow clock unusable in power save
// - Stopped system clock stops counting
// - Timers disabled after reset
// - PWM: counter one reloads A, B alternately
// - PWM restart always reloads A first
// - PWM toggles pin A on underflow
// - PWM reloads set flags A, B
// - PWM: counter two timer, flag D
// - Capture: pin edges copy counter one
// - Preset to all ones after capture
// - Capture: events A, B, C flagged
// - Capture: counter two simple timer
// - Capture: event clocks leave counters stopped
// - Dual: counter one reloads A, toggles
// - Dual: pin A rising toggle sets C
// - Dual: counter two reloads B, flag D
// - Prescaler divides by value plus one
// - Clock selector with no-clock stop
module mft_timer (
    input  wire logic        ref_clk_in,
    input  wire logic        nrst_in,
    input  wire logic [3:0]  addr_in,
    input  wire logic [15:0] wdata_in,
    input  wire logic        wr_in,
    input  wire logic        rd_in,
    output logic      [15:0] rdata_out,
    input  wire logic        timer_pin_a_in,
    output logic             timer_pin_a_out,
    output logic             timer_pin_a_oe_n_out,
    input  wire logic        timer_pin_b_in,
    input  wire logic        low_speed_clock_in,
    output logic             irq_timer1_out,
    output logic             irq_timer2_out
);
    logic [7:0]  ctrl;
    logic [5:0]  clksel;
    logic [4:0]  prescale_divisor_reg;
    logic [4:0]  prsc_cnt;
    logic [15:0] first_down_counter;
    logic [15:0] second_down_counter;
    logic [15:0] reload_capture_reg_a;
    logic [15:0] reload_capture_reg_b;
    logic [3:0]  irq_en;
    logic [3:0]  pend;
    logic        pin_a_q;
    logic        pin_b_q;
    logic        slow_s1;
    logic        slow_s2;
    logic        slow_s3;
    logic        pwm_next_b;
    logic        pin_a_level;
    logic [2:0]  sel1_q;
    logic [1:0]  mode_q;

    mft_pkg::mft_mode_t mode;
    logic prsc_tick;
    logic b_evt;
    logic b_active;
    logic slow_tick;
    logic tick1;
    logic tick2;
    logic uf1;
    logic uf2;
    logic cap_a;
    logic cap_b;
    logic restart1;
    logic [3:0] pend_set;
    logic [3:0] pend_clr;
    logic wr_hit;

    assign mode = mft_pkg::mft_mode_t'(ctrl[mft_pkg::CTL_MODE_LSB +: 2]);
    assign wr_hit = wr_in;

    // Clock source decode shared by both counters
    function automatic logic clk_tick(input logic [2:0] sel, input logic capmode, input logic psave,
                                      input logic p, input logic e, input logic a, input logic s);
        logic t;
        t = 1'b0;
        case (sel)
            mft_pkg::MFT_CLK_PRSC:  t = p;
            mft_pkg::MFT_CLK_EVENT: t = e & ~capmode;
            mft_pkg::MFT_CLK_PACC:  t = p & a & ~capmode;
            mft_pkg::MFT_CLK_SLOW:  t = s & ~psave;
            default:                t = 1'b0;
        endcase
        return t;
    endfunction

    // Pin sampling and slow clock synchroniser
    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            pin_a_q <= 1'b0;
            pin_b_q <= 1'b0;
            slow_s1 <= 1'b0;
            slow_s2 <= 1'b0;
            slow_s3 <= 1'b0;
        end else begin
            pin_a_q <= timer_pin_a_in;
            pin_b_q <= timer_pin_b_in;
            slow_s1 <= low_speed_clock_in;
            slow_s2 <= slow_s1;
            slow_s3 <= slow_s2;
        end
    end

    // Edges of B: rising unless falling selected
    assign b_evt = ctrl[mft_pkg::CTL_BEDGE] ? (pin_b_q & ~timer_pin_b_in) : (~pin_b_q & timer_pin_b_in);
    assign b_active = timer_pin_b_in ^ ctrl[mft_pkg::CTL_BEDGE];
    assign slow_tick = slow_s2 & ~slow_s3;

    // Capture edges; pin A only acts as input in capture mode
    assign cap_a = (mode == mft_pkg::MFT_MODE_CAP) &&
                   (ctrl[mft_pkg::CTL_AEDGE] ? (pin_a_q & ~timer_pin_a_in) : (~pin_a_q & timer_pin_a_in));
    assign cap_b = (mode == mft_pkg::MFT_MODE_CAP) && b_evt;

    // Prescaler: divide by value plus one
    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            prsc_cnt <= mft_pkg::PRSC_RST;
        end else if (prsc_cnt == 5'h00) begin
            prsc_cnt <= prescale_divisor_reg;
        end else begin
            prsc_cnt <= prsc_cnt - 5'h01;
        end
    end
    assign prsc_tick = (prsc_cnt == 5'h00);

    assign tick1 = clk_tick(clksel[2:0], mode == mft_pkg::MFT_MODE_CAP, ctrl[mft_pkg::CTL_PSAVE],
                            prsc_tick, b_evt, b_active, slow_tick);
    assign tick2 = clk_tick(clksel[5:3], mode == mft_pkg::MFT_MODE_CAP, ctrl[mft_pkg::CTL_PSAVE],
                            prsc_tick, b_evt, b_active, slow_tick);
    assign uf1 = tick1 && (first_down_counter == 16'h0000);
    assign uf2 = tick2 && (second_down_counter == 16'h0000);

    // Restart: selector change, mode change, or clock off
    assign restart1 = (clksel[2:0] != sel1_q) || (ctrl[1:0] != mode_q) ||
                      (clksel[2:0] == mft_pkg::MFT_CLK_NONE);

    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            sel1_q <= mft_pkg::MFT_CLK_NONE;
            mode_q <= mft_pkg::MFT_MODE_PWM;
        end else begin
            sel1_q <= clksel[2:0];
            mode_q <= ctrl[1:0];
        end
    end

    // PWM reload alternation
    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            pwm_next_b <= 1'b0;
        end else if (mode != mft_pkg::MFT_MODE_PWM) begin
            pwm_next_b <= 1'b0;
        end else if (restart1) begin
            // A reload in the restart cycle came from A, so B follows
            pwm_next_b <= uf1;
        end else if (uf1) begin
            pwm_next_b <= ~pwm_next_b;
        end
    end

    // First counter: software write, capture preset, reload, count
    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            first_down_counter <= mft_pkg::CNT_RST;
        end else if (wr_hit && addr_in == mft_pkg::OFF_CNT1) begin
            first_down_counter <= wdata_in;
        end else if ((cap_a && ctrl[mft_pkg::CTL_AEN]) || (cap_b && ctrl[mft_pkg::CTL_BEN])) begin
            first_down_counter <= mft_pkg::ALL_ONES;
        end else if (uf1) begin
            case (mode)
                mft_pkg::MFT_MODE_PWM:
                    first_down_counter <= (pwm_next_b && !restart1) ? reload_capture_reg_b : reload_capture_reg_a;
                mft_pkg::MFT_MODE_DUAL:
                    first_down_counter <= reload_capture_reg_a;
                default:
                    first_down_counter <= mft_pkg::ALL_ONES;
            endcase
        end else if (tick1) begin
            first_down_counter <= first_down_counter - 16'h0001;
        end
    end

    // Second counter: free wrap outside dual mode
    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            second_down_counter <= mft_pkg::CNT_RST;
        end else if (wr_hit && addr_in == mft_pkg::OFF_CNT2) begin
            second_down_counter <= wdata_in;
        end else if (uf2 && mode == mft_pkg::MFT_MODE_DUAL) begin
            second_down_counter <= reload_capture_reg_b;
        end else if (tick2) begin
            second_down_counter <= second_down_counter - 16'h0001;
        end
    end

    // Reload/capture registers; capture takes the pre-preset count
    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            reload_capture_reg_a <= mft_pkg::CNT_RST;
            reload_capture_reg_b <= mft_pkg::CNT_RST;
        end else begin
            if (cap_a) begin
                reload_capture_reg_a <= first_down_counter;
            end else if (wr_hit && addr_in == mft_pkg::OFF_CRA) begin
                reload_capture_reg_a <= wdata_in;
            end
            if (cap_b) begin
                reload_capture_reg_b <= first_down_counter;
            end else if (wr_hit && addr_in == mft_pkg::OFF_CRB) begin
                reload_capture_reg_b <= wdata_in;
            end
        end
    end

    // Pin A output level; initial level loaded while counter one stopped
    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            pin_a_level <= 1'b0;
        end else if (clksel[2:0] == mft_pkg::MFT_CLK_NONE) begin
            pin_a_level <= ctrl[mft_pkg::CTL_AOUT];
        end else if (uf1 && ctrl[mft_pkg::CTL_AEN] && mode != mft_pkg::MFT_MODE_CAP) begin
            pin_a_level <= ~pin_a_level;
        end
    end

    // Pending event sources per mode
    always_comb begin
        pend_set = 4'h0;
        case (mode)
            mft_pkg::MFT_MODE_PWM: begin
                pend_set[0] = uf1 & (~pwm_next_b | restart1);
                pend_set[1] = uf1 & pwm_next_b & ~restart1;
                pend_set[3] = uf2;
            end
            mft_pkg::MFT_MODE_CAP: begin
                pend_set[0] = cap_a;
                pend_set[1] = cap_b;
                pend_set[2] = uf1;
                pend_set[3] = uf2;
            end
            mft_pkg::MFT_MODE_DUAL: begin
                pend_set[2] = uf1 & ctrl[mft_pkg::CTL_AEN] & ~pin_a_level;
                pend_set[3] = uf2;
            end
            default: pend_set = 4'h0;
        endcase
    end
    assign pend_clr = (wr_hit && addr_in == mft_pkg::OFF_PCLR) ? wdata_in[3:0] : 4'h0;

    // Set wins over clear
    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            pend <= 4'h0;
        end else begin
            pend <= (pend & ~pend_clr) | pend_set;
        end
    end

    // Control registers; reset leaves both clocks off
    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            ctrl                 <= mft_pkg::CTRL_RST;
            clksel               <= 6'h00;
            prescale_divisor_reg <= mft_pkg::PRSC_RST;
            irq_en               <= 4'h0;
        end else if (wr_hit) begin
            case (addr_in)
                mft_pkg::OFF_CTRL:   ctrl <= wdata_in[7:0];
                mft_pkg::OFF_CLKSEL: clksel <= wdata_in[5:0];
                mft_pkg::OFF_PRSC:   prescale_divisor_reg <= wdata_in[4:0];
                mft_pkg::OFF_IEN:    irq_en <= wdata_in[3:0];
                default: ;
            endcase
        end
    end

    // Read port and registered outputs
    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rdata_out <= mft_pkg::RD_ZERO;
        end else if (rd_in) begin
            case (addr_in)
                mft_pkg::OFF_CTRL:   rdata_out <= {8'h00, ctrl};
                mft_pkg::OFF_CLKSEL: rdata_out <= {10'h000, clksel};
                mft_pkg::OFF_PRSC:   rdata_out <= {11'h000, prescale_divisor_reg};
                mft_pkg::OFF_CNT1:   rdata_out <= first_down_counter;
                mft_pkg::OFF_CNT2:   rdata_out <= second_down_counter;
                mft_pkg::OFF_CRA:    rdata_out <= reload_capture_reg_a;
                mft_pkg::OFF_CRB:    rdata_out <= reload_capture_reg_b;
                mft_pkg::OFF_IEN:    rdata_out <= {12'h000, irq_en};
                mft_pkg::OFF_PND:    rdata_out <= {12'h000, pend};
                default:             rdata_out <= mft_pkg::RD_ZERO;
            endcase
        end else begin
            rdata_out <= mft_pkg::RD_ZERO;
        end
    end

    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            timer_pin_a_out      <= 1'b0;
            timer_pin_a_oe_n_out <= 1'b1;
            irq_timer1_out       <= 1'b0;
            irq_timer2_out       <= 1'b0;
        end else begin
            timer_pin_a_out      <= pin_a_level;
            // Pin A driven only when toggling outside capture mode
            timer_pin_a_oe_n_out <= ~(ctrl[mft_pkg::CTL_AEN] && mode != mft_pkg::MFT_MODE_CAP);
            // Dual mode: flag C answers to enable A
            irq_timer1_out       <= (mode == mft_pkg::MFT_MODE_DUAL) ? (pend[2] & irq_en[0])
                                                                     : |(pend[2:0] & irq_en[2:0]);
            irq_timer2_out       <= pend[3] & irq_en[3];
        end
    end

    // Assertions
    prsc_period_a: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
        (prsc_cnt == 5'h01 && prescale_divisor_reg == $past(prescale_divisor_reg)) |=> prsc_tick)
        else $error("prescaler tick missing");
    cap_noevent_a: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
        (mode == mft_pkg::MFT_MODE_CAP && clksel[2:0] == mft_pkg::MFT_CLK_EVENT) |-> !tick1)
        else $error("event clock in capture mode");
    cap_nopacc_a: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
        (mode == mft_pkg::MFT_MODE_CAP && clksel[5:3] == mft_pkg::MFT_CLK_PACC) |-> !tick2)
        else $error("pulse accumulate in capture mode");
    pacc_gate_a: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
        (clksel[2:0] == mft_pkg::MFT_CLK_PACC && tick1) |-> (prsc_tick && b_active))
        else $error("pulse accumulate tick without gate");
    psave_slow_a: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
        (ctrl[mft_pkg::CTL_PSAVE] && clksel[2:0] == mft_pkg::MFT_CLK_SLOW) |-> !tick1)
        else $error("slow clock used in power save");
    pwm_reload_a: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
        (mode == mft_pkg::MFT_MODE_PWM && uf1 && !pwm_next_b && !restart1 && !wr_hit && !cap_a && !cap_b)
        |=> (first_down_counter == $past(reload_capture_reg_a)) && pend[0])
        else $error("pwm reload from a wrong");
    toggle_pin_a: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
        (uf1 && ctrl[mft_pkg::CTL_AEN] && mode != mft_pkg::MFT_MODE_CAP && clksel[2:0] != 3'b000)
        |=> ##1 (timer_pin_a_out != $past(timer_pin_a_out))) else $error("pin a did not toggle");
    capture_a_a: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
        cap_a |=> (reload_capture_reg_a == $past(first_down_counter)) && pend[0])
        else $error("capture a wrong");
    preset_a: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
        (cap_b && ctrl[mft_pkg::CTL_BEN] && !(wr_hit && addr_in == mft_pkg::OFF_CNT1))
        |=> first_down_counter == mft_pkg::ALL_ONES) else $error("preset missing");
    dual_reload_a: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
        (mode == mft_pkg::MFT_MODE_DUAL && uf2 && !(wr_hit && addr_in == mft_pkg::OFF_CNT2))
        |=> second_down_counter == $past(reload_capture_reg_b) && pend[3])
        else $error("dual reload b wrong");
    reset_off_a: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
        $rose(nrst_in) |-> clksel == 6'h00) else $error("timers not disabled");
    pwm_restart_a: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
        (mode == mft_pkg::MFT_MODE_PWM && uf1 && restart1 && !wr_hit && !cap_a && !cap_b)
        |=> first_down_counter == $past(reload_capture_reg_a) && pend[0] && pwm_next_b)
        else $error("pwm restart did not reload a");
    dual_irq_a: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
        (mode == mft_pkg::MFT_MODE_DUAL && pend[2] && irq_en[0]) |=> irq_timer1_out)
        else $error("dual flag c interrupt missing");
    pin_a_drive_a: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
        (ctrl[mft_pkg::CTL_AEN] && mode == mft_pkg::MFT_MODE_PWM) |=> !timer_pin_a_oe_n_out)
        else $error("pin a not driven");
endmodule
`default_nettype wire

// ---- mft_pin_model.sv ----
// Pin-side partner model: pin A capture source, pin B events, slow clock
`default_nettype none
module mft_pin_model (
    input  wire logic ref_clk_in,
    input  wire logic pin_a_drv_in,
    input  wire logic pin_a_oe_n_in,
    output logic      pin_a_out,
    output logic      pin_b_out,
    output logic      slow_clk_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic       ext_a = 1'b0;
    logic       slow_run = 1'b0;
    logic [2:0] slow_div = 3'h0;
    initial pin_b_out = 1'b0;
    initial slow_clk_out = 1'b0;
    // Device owns pin A while its enable is low
    assign pin_a_out = pin_a_oe_n_in ? ext_a : pin_a_drv_in;
    // Eight system clocks a period; parked low when idle
    always @(posedge ref_clk_in) begin
        slow_div     <= slow_run ? slow_div + 3'h1 : 3'h0;
        slow_clk_out <= slow_run & slow_div[2];
    end
    // Levels are held for whole clocks, never under one
    task automatic hold_b(input logic lvl, input int w);
        pin_b_out <= lvl;
        repeat (w) @(posedge ref_clk_in);
    endtask
    task automatic pulse_b(input int n, input int w);
        repeat (n) begin
            hold_b(~pin_b_out, w);
            hold_b(~pin_b_out, w);
        end
    endtask
    task automatic edge_a(input logic lvl);
        ext_a <= lvl;
        repeat (3) @(posedge ref_clk_in);
    endtask
endmodule
`default_nettype wire

// ---- mft_timer_tb.sv ----
// Self-checking bench: register sequences against the pin-side model
`default_nettype none
module mft_timer_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        ref_clk_in, nrst_in, wr_in, rd_in, clk_hold;
    logic [3:0]  addr_in;
    logic [15:0] wdata_in, rdata_out, v0, v1, obs;
    logic        timer_pin_a_in, timer_pin_a_out, timer_pin_a_oe_n_out, timer_pin_b_in;
    logic        low_speed_clock_in, irq_timer1_out, irq_timer2_out;
    int          mismatches, num_checks, cycles, n;

    mft_timer uut (
        .ref_clk_in, .nrst_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out,
        .timer_pin_a_in, .timer_pin_a_out, .timer_pin_a_oe_n_out, .timer_pin_b_in,
        .low_speed_clock_in, .irq_timer1_out, .irq_timer2_out
    );
    mft_pin_model pins (
        .ref_clk_in, .pin_a_drv_in(timer_pin_a_out), .pin_a_oe_n_in(timer_pin_a_oe_n_out),
        .pin_a_out(timer_pin_a_in), .pin_b_out(timer_pin_b_in), .slow_clk_out(low_speed_clock_in)
    );
    // Bit 3 pin A enable, 2 pin A level, 1 and 0 the two interrupts
    assign obs = {12'h000, timer_pin_a_oe_n_out, timer_pin_a_out, irq_timer2_out, irq_timer1_out};

    initial begin
        ref_clk_in = 1'b0;
        clk_hold = 1'b0;
        forever begin
            #4;
            if (!clk_hold) ref_clk_in = ~ref_clk_in;
        end
    end
    // Sequence needs about 560 cycles
    always @(posedge ref_clk_in) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            mismatches = mismatches + 1;
            give_verdict();
        end
    end

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        addr_in  <= a;
        wdata_in <= d;
        wr_in    <= 1'b1;
        @(posedge ref_clk_in);
        wr_in <= 1'b0;
        @(posedge ref_clk_in);
    endtask
    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        addr_in <= a;
        rd_in   <= 1'b1;
        @(posedge ref_clk_in);
        rd_in <= 1'b0;
        #1;
        d = rdata_out;
        @(posedge ref_clk_in);
    endtask
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chk(input string what, input logic [3:0] a, input logic [15:0] exp);
        logic [15:0] d;
        rd(a, d);
        check(what, exp, d);
    endtask
    // Cycles until pin A next changes, bounded
    task automatic wait_toggle(output int cnt);
        logic last;
        last = timer_pin_a_out;
        cnt = 0;
        while (timer_pin_a_out === last && cnt < 300) begin
            @(posedge ref_clk_in);
            cnt++;
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    initial begin
        nrst_in = 1'b0;
        addr_in = 4'h0;
        wdata_in = 16'h0000;
        wr_in = 1'b0;
        rd_in = 1'b0;
        repeat (10) @(posedge ref_clk_in);
        nrst_in <= 1'b1;
        @(posedge ref_clk_in);
        check("pins", 16'h0008, obs);
        chk("ctrl", 4'h0, 16'h0000);
        chk("clksel", 4'h1, 16'h0000);
        chk("prsc", 4'h2, 16'h0000);
        chk("pend", 4'h8, 16'h0000);
        wr(4'hf, 16'h1234);
        chk("unmapped", 4'hf, 16'h0000);
        wr(4'h0, 16'h0016);
        wr(4'h3, 16'h0005);
        repeat (20) @(posedge ref_clk_in);
        chk("held cnt1", 4'h3, 16'h0005);
        check("init level", 16'h0004, obs & 16'h000c);
        // Clock stopped mid-interval must not disturb the rate
        wr(4'h2, 16'h0003);
        chk("prsc", 4'h2, 16'h0003);
        wr(4'h5, 16'h8000);
        wr(4'h3, 16'h4000);
        wr(4'h1, 16'h0001);
        rd(4'h3, v0);
        clk_hold = 1'b1;
        #202;
        clk_hold = 1'b0;
        repeat (38) @(posedge ref_clk_in);
        rd(4'h3, v1);
        check("prescaled", 16'h000a, v0 - v1);
        wr(4'h1, 16'h0000);
        wr(4'h0, 16'h0006);
        wr(4'h2, 16'h0000);
        wr(4'h5, 16'h0004);
        wr(4'h6, 16'h0002);
        wr(4'h3, 16'h0002);
        wr(4'h7, 16'h0009);
        wr(4'h9, 16'h000f);
        wr(4'h1, 16'h0009);
        wait_toggle(n);
        wait_toggle(n);
        check("dual period", 16'h0005, 16'(n));
        wr(4'h1, 16'h0000);
        rd(4'h8, v0);
        check("dual pend", 16'h000c, v0 & 16'h000c);
        check("dual irq", 16'h0003, obs & 16'h000b);
        wr(4'h9, 16'h000f);
        chk("cleared", 4'h8, 16'h0000);
        wr(4'h0, 16'h0004);
        wr(4'h5, 16'h0003);
        wr(4'h6, 16'h0006);
        wr(4'h7, 16'h0000);
        // First pass stops right after a load from A, so B would come next
        for (int r = 0; r < 2; r++) begin
            wr(4'h3, 16'h0002);
            wr(4'h4, 16'h0005);
            wr(4'h1, 16'h0009);
            wait_toggle(n);
            wait_toggle(n);
            check("pwm a", 16'h0004, 16'(n));
            wait_toggle(n);
            check("pwm b", 16'h0007, 16'(n));
            wr(4'h1, 16'h0000);
        end
        chk("pwm pend", 4'h8, 16'h000b);
        check("masked irq", 16'h0000, obs & 16'h0003);
        wr(4'h7, 16'h0002);
        @(posedge ref_clk_in);
        check("enabled irq", 16'h0001, obs & 16'h0003);
        pins.hold_b(1'b1, 2);
        wr(4'h0, 16'h0049);
        wr(4'h3, 16'h1234);
        wr(4'h9, 16'h000f);
        pins.edge_a(1'b1);
        chk("capture a", 4'h5, 16'h1234);
        wr(4'h3, 16'h0abc);
        pins.hold_b(1'b0, 3);
        pins.hold_b(1'b1, 3);
        chk("capture b", 4'h6, 16'h0abc);
        chk("preset", 4'h3, 16'hffff);
        chk("cap pend", 4'h8, 16'h0003);
        check("pin a input", 16'h0008, obs & 16'h0008);
        wr(4'h7, 16'h000c);
        wr(4'h3, 16'h0001);
        wr(4'h4, 16'h0001);
        wr(4'h1, 16'h0009);
        repeat (8) @(posedge ref_clk_in);
        wr(4'h1, 16'h0000);
        chk("uflow pend", 4'h8, 16'h000f);
        check("cap irq", 16'h0003, obs & 16'h0003);
        wr(4'h3, 16'h0100);
        wr(4'h4, 16'h0100);
        wr(4'h0, 16'h0041);
        wr(4'h1, 16'h001a);
        pins.pulse_b(4, 3);
        chk("no event", 4'h3, 16'h0100);
        chk("no accum", 4'h4, 16'h0100);
        for (int pol = 0; pol < 2; pol++) begin
            wr(4'h1, 16'h0000);
            pins.hold_b(pol[0], 2);
            wr(4'h0, pol[0] ? 16'h0042 : 16'h0002);
            wr(4'h3, 16'h0100);
            wr(4'h4, 16'h0100);
            wr(4'h1, 16'h0013);
            pins.pulse_b(5, 3);
            repeat (4) @(posedge ref_clk_in);
            chk("accum", 4'h3, 16'h00f1);
            chk("events", 4'h4, 16'h00fb);
        end
        for (int ps = 0; ps < 2; ps++) begin
            wr(4'h0, ps[0] ? 16'h0082 : 16'h0002);
            wr(4'h4, 16'h0100);
            wr(4'h1, 16'h0020);
            pins.slow_run <= 1'b1;
            repeat (84) @(posedge ref_clk_in);
            pins.slow_run <= 1'b0;
            rd(4'h4, v0);
            check("slow", ps[0] ? 16'h0000 : 16'h000a, 16'h0100 - v0);
        end
        give_verdict();
    end
endmodule
`default_nettype wire
